/* File: src/dlrc_pkg.sv */
// Package of constants for the dual-core low-power and reset controller
package dlrc_pkg;
  // Reset vector presented to the cores
  localparam logic [15:0] RESET_VECTOR = 16'h8000;
  // Power-on delay in FLL (system clock) cycles
  localparam int POR_DELAY_CYCLES = 65536;
  // Watchdog reset hold in system clock cycles
  localparam int WDOG_HOLD_CYCLES = 9;
  // Exit delay after external pin release, longest allowed is 12
  localparam int EXT_EXIT_CYCLES = 12;
  // Least low time of the pin that is recognised
  localparam int EXT_MIN_LOW_CYCLES = 4;
  // Reset values of control bits
  localparam logic STOP_BROWNOUT_DISABLE_RST = 1'b0;
  localparam logic RESET_PIN_DISABLE_RST = 1'b0;
  localparam logic [2:0] CLK_CTRL_RST = 3'h0;
  // Width of the stretch counter
  localparam int STRETCH_W = 17;
  typedef enum logic [1:0] {
    DLRC_RUN,
    DLRC_STOP
  } dlrc_pwr_t;
endpackage

/* File: src/dlrc_stretch.sv */
// Reset stretch counter: holds reset until a loaded count expires
module dlrc_stretch #(
  parameter int W = 17
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic load, // Reload the count, source still active
  input wire logic [W-1:0] count, // Cycles to hold after load drops
  output logic busy // High while count runs or load is high
);
  logic [W-1:0] cnt_reg;

  // Count down after the last load
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      busy <= 1'b1;
    end else if (load) begin
      cnt_reg <= count;
      busy <= 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
      busy <= (cnt_reg != {{(W-1){1'b0}}, 1'b1});
    end else begin
      busy <= 1'b0;
    end
  end
endmodule

/* File: src/dlrc_top.sv */
// Low-power mode and reset controller of a dual-core microcontroller
//
// Overview of operation
// - Supervisor core alone enters stop on write
// - Stop halts all clocks except 32k domain
// - Stop entry keeps clock select bits unchanged
// - Reset exit from stop restores clock defaults
// - Stop exits on listed wake sources
// - Stop disables signal core until re-enabled
// - Signal core idle freezes instruction pointer
// - Idle ends on core interrupts or signal core reset
// - Idle exit clears bit, vectors, resumes
// - Signal core reset ends idle, clears bit
// - All reset sources give same state, except power control bits and flags
// - Power-on counts 65536 FLL cycles, vector 8000h
// - Brownout holds reset, recovers with full delay unless another source reloads the count
// - Power-on flag set, held until cleared
// - Stop brownout disable masks detection in stop
// - Watchdog reset holds nine clock cycles
// - Watchdog flag set, held until cleared
// - Pin release exits reset within twelve
// - Reset during stop exits to 8000h
// - Pin reset enabled, disable bit frees pin
// - Writing zero to port pin resets
// - Power-on flag cleared only by software
module dlrc_top #(
  parameter int POR_DELAY = dlrc_pkg::POR_DELAY_CYCLES // Shorten in simulation
) (
  input wire logic sys_clk, // FLL system clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic supply_ok, // Supply above reset threshold voltage
  input wire logic wdog_timeout, // Watchdog expired while enabled
  input wire logic ext_reset_pin_b, // External reset pin, active low
  input wire logic port_pin_wr, // Software write to shared port pin
  input wire logic port_pin_wdata, // Value written to port pin
  input wire logic internal_reset_req, // Internal system reset request
  input wire logic stop_wr, // Supervisor core sets stop bit
  input wire logic ext_int_wake, // Enabled external interrupt pending
  input wire logic rtc_alarm, // Time-of-day or subsecond alarm
  input wire logic twowire_start_int, // Two-wire start interrupt
  input wire logic twowire_start_int_enable, // Start interrupt enable
  input wire logic twowire_enable, // Two-wire controller enable
  input wire logic supply_monitor_int, // Supply monitor interrupt
  input wire logic supply_monitor_int_enable, // Supply monitor int enable
  input wire logic clk_ctrl_wr, // Write to clock select bits
  input wire logic [2:0] clk_ctrl_wdata, // Clock select and divider data
  input wire logic sig_en_wr, // Write to signal core enable
  input wire logic sig_en_wdata, // Signal core enable data
  input wire logic idle_wr, // Signal core sets idle bit
  input wire logic master_req_int, // Master request to signal core
  input wire logic adc_buf_int, // ADC output buffer interrupt
  input wire logic sig_int_enable, // Signal core interrupts enabled
  input wire logic flag_wr, // Write to watchdog control flags
  input wire logic por_flag_wdata, // New power-on flag value
  input wire logic wdog_flag_wdata, // New watchdog reset flag value
  input wire logic pwr_ctrl_wr, // Write to power control register
  input wire logic stop_brownout_disable_wdata, // Stop brownout disable data
  input wire logic reset_pin_disable_wdata, // Reset pin disable data
  output logic sys_reset_b, // Merged system reset, active low
  output logic [15:0] reset_vector, // Fetch address after reset
  output logic stop_mode, // Supervisor core in stop
  output logic fast_clk_en, // Gate for all non-32k clocks
  output logic [2:0] clk_ctrl, // Clock select and divider bits
  output logic signal_core_enable, // Signal core running
  output logic sig_core_reset_b, // Signal core reset, active low
  output logic sig_idle, // Signal core idle bit
  output logic ip_freeze, // Hold signal core instruction pointer
  output logic sig_vector_take, // Pulse: signal core takes interrupt
  output logic por_flag, // Power-on reset flag
  output logic watchdog_reset_flag, // Watchdog reset flag
  output logic stop_brownout_disable, // Brownout off in stop
  output logic reset_pin_disable, // Pin reset function off
  output logic pin_alt_func // Pin free for alternate use
);
  // Load cycles are brownout cycles, so the full count runs after recovery
  localparam logic [dlrc_pkg::STRETCH_W-1:0] POR_LOAD = dlrc_pkg::STRETCH_W'(POR_DELAY);
  localparam logic [dlrc_pkg::STRETCH_W-1:0] WDOG_LOAD =
    dlrc_pkg::STRETCH_W'(dlrc_pkg::WDOG_HOLD_CYCLES - 1);
  localparam logic [dlrc_pkg::STRETCH_W-1:0] EXT_LOAD =
    dlrc_pkg::STRETCH_W'(dlrc_pkg::EXT_EXIT_CYCLES - 3);
  // Saturates one short, so the fourth low sample already resets
  localparam logic [2:0] PIN_LOW_MAX = 3'(dlrc_pkg::EXT_MIN_LOW_CYCLES - 1);

  dlrc_pkg::dlrc_pwr_t pwr_reg;
  logic brownout;
  logic wake_any;
  logic [2:0] pin_low_cnt_reg;
  logic pin_reset;
  logic wdog_hold_reg;
  logic src_load;
  logic [dlrc_pkg::STRETCH_W-1:0] src_count;
  logic stretch_busy;
  logic sys_in_reset;
  logic sig_wake;

  // Brownout seen in run, masked in stop when disabled
  // masked in stop
  assign brownout = !supply_ok &&
    !(pwr_reg == dlrc_pkg::DLRC_STOP && stop_brownout_disable);

  // Wake sources of stop mode
  // wake source merge
  assign wake_any = ext_int_wake || rtc_alarm ||
    (twowire_start_int && twowire_start_int_enable && twowire_enable) ||
    (supply_monitor_int && supply_monitor_int_enable);

  // Pin low counter; shorter pulses are not recognised
  // four-cycle recognition
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_low_cnt_reg <= 3'h0;
    end else if (ext_reset_pin_b || reset_pin_disable) begin
      pin_low_cnt_reg <= 3'h0;
    end else if (pin_low_cnt_reg != PIN_LOW_MAX) begin
      pin_low_cnt_reg <= pin_low_cnt_reg + 3'h1;
    end
  end

  // pin reset gated by disable bit
  assign pin_reset = (!reset_pin_disable &&
    ((pin_low_cnt_reg == PIN_LOW_MAX && !ext_reset_pin_b) ||
     (port_pin_wr && !port_pin_wdata)));

  // Watchdog hold request, so that a one-cycle timeout still stretches
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wdog_hold_reg <= 1'b0;
    end else begin
      wdog_hold_reg <= wdog_timeout;
    end
  end

  // Pick the stretch for the active source; power-on dominates
  // power-on delay
  always_comb begin
    src_load = 1'b0;
    src_count = EXT_LOAD;
    if (brownout) begin
      src_load = 1'b1;
      src_count = POR_LOAD;
    end else if (pin_reset || internal_reset_req) begin
      src_load = 1'b1;
      src_count = EXT_LOAD;
    end else if (wdog_hold_reg) begin
      src_load = 1'b1;
      src_count = WDOG_LOAD;
    end
  end

  dlrc_stretch #(
    .W(dlrc_pkg::STRETCH_W)
  ) u_stretch (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(src_load),
    .count(src_count),
    .busy(stretch_busy)
  );

  // A pin reload after a brownout cuts the count to the shorter EXT_LOAD;
  // the brownout is remembered until release only to keep por_flag set
  logic por_pending_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      por_pending_reg <= 1'b1;
    end else if (brownout) begin
      por_pending_reg <= 1'b1;
    end else if (!stretch_busy) begin
      por_pending_reg <= 1'b0;
    end
  end

  assign sys_in_reset = src_load || stretch_busy;

  // Merged reset, asserted at once, released after stretch
  // merged reset output
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sys_reset_b <= 1'b0;
      reset_vector <= dlrc_pkg::RESET_VECTOR;
    end else begin
      sys_reset_b <= !sys_in_reset;
      reset_vector <= dlrc_pkg::RESET_VECTOR;
    end
  end

  // Stop mode state; reset ends stop and restarts at the vector
  // stop on write
  always_ff @(posedge sys_clk) begin
    if (!rst_b || sys_in_reset) begin
      pwr_reg <= dlrc_pkg::DLRC_RUN;
    end else begin
      unique case (pwr_reg)
        dlrc_pkg::DLRC_RUN: if (stop_wr) pwr_reg <= dlrc_pkg::DLRC_STOP;
        dlrc_pkg::DLRC_STOP: if (wake_any) pwr_reg <= dlrc_pkg::DLRC_RUN;
      endcase
    end
  end

  // Stop indication and fast clock gate, 32k domain unaffected
  // clock halt in stop
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stop_mode <= 1'b0;
      fast_clk_en <= 1'b1;
    end else begin
      stop_mode <= (pwr_reg == dlrc_pkg::DLRC_STOP) && !sys_in_reset;
      fast_clk_en <= !((pwr_reg == dlrc_pkg::DLRC_STOP) && !sys_in_reset &&
        !wake_any) || (pwr_reg == dlrc_pkg::DLRC_RUN && !stop_wr);
    end
  end

  // Clock control: kept across stop, defaults on any reset
  // clock bits kept
  always_ff @(posedge sys_clk) begin
    if (!rst_b || sys_in_reset) begin
      clk_ctrl <= dlrc_pkg::CLK_CTRL_RST;
    end else if (clk_ctrl_wr && pwr_reg == dlrc_pkg::DLRC_RUN) begin
      clk_ctrl <= clk_ctrl_wdata;
    end
  end

  // Signal core enable: stop forces it off, software turns it back on
  // disable on stop
  always_ff @(posedge sys_clk) begin
    if (!rst_b || sys_in_reset) begin
      signal_core_enable <= 1'b0;
    end else if (stop_wr || pwr_reg == dlrc_pkg::DLRC_STOP) begin
      signal_core_enable <= 1'b0;
    end else if (sig_en_wr) begin
      signal_core_enable <= sig_en_wdata;
    end
  end

  // Signal core reset from global reset or enable cleared
  // signal core reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sig_core_reset_b <= 1'b0;
    end else begin
      sig_core_reset_b <= !sys_in_reset && signal_core_enable;
    end
  end

  assign sig_wake = sig_int_enable && (master_req_int || adc_buf_int);

  // Idle bit; wake clears it and vectors, core reset clears it
  // idle freezes pointer
  always_ff @(posedge sys_clk) begin
    if (!rst_b || sys_in_reset || !signal_core_enable) begin
      sig_idle <= 1'b0;
      ip_freeze <= 1'b0;
      sig_vector_take <= 1'b0;
    end else if (sig_idle && sig_wake) begin
      sig_idle <= 1'b0;
      ip_freeze <= 1'b0;
      sig_vector_take <= 1'b1;
    end else begin
      sig_idle <= sig_idle || idle_wr;
      ip_freeze <= sig_idle || idle_wr;
      sig_vector_take <= 1'b0;
    end
  end

  // Status flags; set wins over a software clear
  // power-on flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      por_flag <= 1'b1;
      watchdog_reset_flag <= 1'b0;
    end else begin
      if (brownout || por_pending_reg) begin
        por_flag <= 1'b1;
      end else if (flag_wr) begin
        por_flag <= por_flag_wdata;
      end
      if (wdog_timeout) begin
        watchdog_reset_flag <= 1'b1;
      end else if (flag_wr && !sys_in_reset) begin
        watchdog_reset_flag <= wdog_flag_wdata;
      end
    end
  end

  // Power control bits, defaults only on power-on
  // disable bit
  always_ff @(posedge sys_clk) begin
    if (!rst_b || brownout) begin
      stop_brownout_disable <= dlrc_pkg::STOP_BROWNOUT_DISABLE_RST;
      reset_pin_disable <= dlrc_pkg::RESET_PIN_DISABLE_RST;
      pin_alt_func <= 1'b0;
    end else if (pwr_ctrl_wr && !sys_in_reset) begin
      stop_brownout_disable <= stop_brownout_disable_wdata;
      reset_pin_disable <= reset_pin_disable_wdata;
      pin_alt_func <= reset_pin_disable_wdata;
    end
  end

  // Watchdog hold lasts exactly nine cycles from the hold request
  AST_WDOG_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(wdog_hold_reg) && !brownout && !pin_reset && !internal_reset_req &&
    !stretch_busy ##1 !src_load[*8] |-> ##1 !sys_reset_b ##1 sys_reset_b)
    else $error("watchdog hold length wrong");

  // Pin release leaves reset within twelve cycles
  AST_PIN_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(pin_reset) && !brownout && !por_pending_reg && !wdog_hold_reg
    ##1 !src_load[*8] |-> ##[0:4] sys_reset_b)
    else $error("pin release exit too slow");

  // Short pin pulses are ignored
  AST_PIN_MIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(ext_reset_pin_b) |-> (!pin_reset || (port_pin_wr && !port_pin_wdata)) [*3])
    else $error("pin reset too early");

  // Brownout holds reset
  AST_BROWNOUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    brownout |=> !sys_reset_b)
    else $error("brownout did not hold reset");

  // Stop drops the signal core enable
  AST_STOP_SIG: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stop_wr |=> !signal_core_enable)
    else $error("signal core kept running into stop");

  // Clock bits unchanged across stop
  AST_CLK_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pwr_reg == dlrc_pkg::DLRC_STOP && !sys_in_reset |=> $stable(clk_ctrl))
    else $error("clock bits changed in stop");

  // Reset returns clock bits to defaults
  AST_CLK_RST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sys_in_reset |=> clk_ctrl == dlrc_pkg::CLK_CTRL_RST)
    else $error("clock bits not defaulted by reset");

  // Idle wake clears bit and takes the vector
  AST_IDLE_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sig_idle && sig_wake && signal_core_enable && !sys_in_reset |=>
    !sig_idle && sig_vector_take)
    else $error("idle wake not taken");

  // Watchdog flag sets after timeout
  AST_WDOG_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wdog_timeout |=> watchdog_reset_flag)
    else $error("watchdog flag not set");

  // Stop ends on reset
  AST_STOP_RST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sys_in_reset |=> pwr_reg == dlrc_pkg::DLRC_RUN)
    else $error("reset did not end stop");
endmodule

/* File: verification/dlrc_partner.sv */
// Far-side model: external reset driver and stop-mode wake sources
module dlrc_partner (
  input wire logic sys_clk, // System clock
  output logic ext_reset_pin_b, // Reset pin, pulled up when idle
  output logic [3:0] wake // Ext int, alarm, start int, supply int
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels: pin pulled up, no wake pending
  initial begin
    ext_reset_pin_b = 1'b1;
    wake = 4'h0;
  end

  // pin low time
  // Caller chooses the low time; three cycles is a deliberate short glitch
  task pin_low(input int n);
    ext_reset_pin_b = 1'b0;
    repeat (n) @(negedge sys_clk);
    ext_reset_pin_b = 1'b1;
  endtask

  // Wake level held n cycles, so answers can be prompt or slow
  task raise(input int k, input int n);
    wake[k] = 1'b1;
    repeat (n) @(negedge sys_clk);
    wake[k] = 1'b0;
  endtask
endmodule

/* File: verification/dlrc_top_test.sv */
// Self-checking bench for the low-power and reset controller
module dlrc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 16;
  logic sys_clk, rst_b, supply_ok, wdog_timeout, port_pin_wr, port_pin_wdata;
  logic internal_reset_req, stop_wr, twowire_start_int_enable, twowire_enable;
  logic supply_monitor_int_enable, clk_ctrl_wr, sig_en_wr, sig_en_wdata, idle_wr;
  logic master_req_int, adc_buf_int, sig_int_enable, flag_wr, por_flag_wdata;
  logic wdog_flag_wdata, pwr_ctrl_wr, stop_brownout_disable_wdata, reset_pin_disable_wdata;
  logic [2:0] clk_ctrl_wdata, clk_ctrl, v;
  logic ext_reset_pin_b, sys_reset_b, stop_mode, fast_clk_en, signal_core_enable;
  logic sig_core_reset_b, sig_idle, ip_freeze, sig_vector_take, por_flag;
  logic watchdog_reset_flag, stop_brownout_disable, reset_pin_disable, pin_alt_func;
  logic [15:0] reset_vector, rnd;
  logic [3:0] wake;
  logic ex;
  int n_fail, n_checks, lows, last, np;

  dlrc_top #(.POR_DELAY(POR)) u_dlrc_top (.sys_clk, .rst_b, .supply_ok, .wdog_timeout,
    .ext_reset_pin_b, .port_pin_wr, .port_pin_wdata, .internal_reset_req, .stop_wr,
    .ext_int_wake(wake[0]), .rtc_alarm(wake[1]), .twowire_start_int(wake[2]),
    .twowire_start_int_enable, .twowire_enable, .supply_monitor_int(wake[3]),
    .supply_monitor_int_enable, .clk_ctrl_wr, .clk_ctrl_wdata, .sig_en_wr, .sig_en_wdata,
    .idle_wr, .master_req_int, .adc_buf_int, .sig_int_enable, .flag_wr, .por_flag_wdata,
    .wdog_flag_wdata, .pwr_ctrl_wr, .stop_brownout_disable_wdata, .reset_pin_disable_wdata,
    .sys_reset_b, .reset_vector, .stop_mode, .fast_clk_en, .clk_ctrl, .signal_core_enable,
    .sig_core_reset_b, .sig_idle, .ip_freeze, .sig_vector_take, .por_flag,
    .watchdog_reset_flag, .stop_brownout_disable, .reset_pin_disable, .pin_alt_func);
  dlrc_partner u_dlrc_partner (.sys_clk, .ext_reset_pin_b, .wake);

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Galois shift register, repeatable stimulus
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction

  // Which sources end stop for given enables
  function automatic logic wakes(input int k, input logic se, input logic en, input logic sm);
    return (k < 2) ? 1'b1 : ((k == 2) ? (se & en) : sm);
  endfunction

  task chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task chk3(input string nm, input logic [2:0] e, input logic [2:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Count held within lo..hi
  task chkn(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Bounded watch of reset: number of low cycles and last low one
  task watch(input int n, output int lo, output int la);
    lo = 0;
    la = 0;
    for (int i = 1; i <= n; i++) begin
      cyc(1);
      if (sys_reset_b !== 1'b1) begin
        lo++;
        la = i;
      end
    end
  endtask

  task stop_pulse();
    stop_wr = 1'b1;
    cyc(1);
    stop_wr = 1'b0;
    cyc(1);
  endtask

  task pwr_write(input logic sbd, input logic rpd);
    pwr_ctrl_wr = 1'b1;
    stop_brownout_disable_wdata = sbd;
    reset_pin_disable_wdata = rpd;
    cyc(1);
    pwr_ctrl_wr = 1'b0;
    cyc(1);
  endtask

  task port_write(input logic d);
    port_pin_wr = 1'b1;
    port_pin_wdata = d;
    cyc(1);
    port_pin_wr = 1'b0;
  endtask

  task print_verdict();
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    {rst_b, supply_ok, wdog_timeout, port_pin_wr, port_pin_wdata, internal_reset_req} = 6'h0;
    {stop_wr, twowire_start_int_enable, twowire_enable, supply_monitor_int_enable} = 4'h0;
    {clk_ctrl_wr, sig_en_wr, sig_en_wdata, idle_wr, master_req_int, adc_buf_int} = 6'h0;
    {sig_int_enable, flag_wr, por_flag_wdata, wdog_flag_wdata, pwr_ctrl_wr} = 5'h0;
    {stop_brownout_disable_wdata, reset_pin_disable_wdata, clk_ctrl_wdata} = 5'h0;
    n_fail = 0;
    n_checks = 0;
    rnd = 16'h8b2c;
    // Power-on: reset held, then supply rises
    cyc(6);
    rst_b = 1'b1;
    cyc(2);
    supply_ok = 1'b1;
    watch(POR + 12, lows, last);
    chkn("por_delay", POR, POR + 4, lows);
    chk16("reset_vector", 16'h8000, reset_vector);
    chk1("por_flag", 1'b1, por_flag);
    chk1("wdog_flag", 1'b0, watchdog_reset_flag);
    chk1("sbd", 1'b0, stop_brownout_disable);
    chk1("pin_disable", 1'b0, reset_pin_disable);
    chk3("clk_ctrl", 3'h0, clk_ctrl);
    // Software clears power-on flag; nothing else sets it
    flag_wr = 1'b1;
    cyc(1);
    flag_wr = 1'b0;
    cyc(20);
    chk1("por_flag", 1'b0, por_flag);
    // Watchdog timeout
    wdog_timeout = 1'b1;
    cyc(1);
    wdog_timeout = 1'b0;
    watch(30, lows, last);
    chkn("wdog_hold", 9, 9, lows);
    chk1("wdog_flag", 1'b1, watchdog_reset_flag);
    chk1("por_flag", 1'b0, por_flag);
    flag_wr = 1'b1;
    cyc(1);
    flag_wr = 1'b0;
    cyc(1);
    chk1("wdog_flag", 1'b0, watchdog_reset_flag);
    // Internal request
    internal_reset_req = 1'b1;
    cyc(3);
    internal_reset_req = 1'b0;
    watch(30, lows, last);
    chkn("int_reset", 1, 29, lows);
    // Pin pulses: short glitch refused, longer ones reset
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      np = (i == 0) ? 3 : ((i == 1) ? 4 : 4 + int'(rnd[2:0]));
      u_dlrc_partner.pin_low(np);
      watch(20, lows, last);
      chkn("pin_reset", (np < 4) ? 0 : 1, (np < 4) ? 0 : 20, lows);
      chkn("pin_exit", 0, 12, last);
    end
    port_write(1'b1);
    watch(16, lows, last);
    chkn("port_one", 0, 0, lows);
    port_write(1'b0);
    watch(16, lows, last);
    chkn("port_zero", 1, 16, lows);
    // Pin function off: pin and port writes ignored
    pwr_write(1'b0, 1'b1);
    chk1("pin_disable", 1'b1, reset_pin_disable);
    chk1("pin_alt", 1'b1, pin_alt_func);
    u_dlrc_partner.pin_low(6);
    port_write(1'b0);
    watch(16, lows, last);
    chkn("pin_off", 0, 0, lows);
    pwr_write(1'b1, 1'b0);
    chk1("sbd", 1'b1, stop_brownout_disable);
    // Stop entry keeps clock bits, halts clocks, drops signal core
    rnd = lfsr(rnd);
    v = rnd[2:0];
    sig_en_wr = 1'b1;
    sig_en_wdata = 1'b1;
    clk_ctrl_wr = 1'b1;
    clk_ctrl_wdata = v;
    cyc(1);
    {sig_en_wr, clk_ctrl_wr} = 2'h0;
    cyc(1);
    chk1("sig_en", 1'b1, signal_core_enable);
    stop_pulse();
    clk_ctrl_wr = 1'b1;
    clk_ctrl_wdata = ~v;
    cyc(1);
    clk_ctrl_wr = 1'b0;
    cyc(1);
    chk1("stop", 1'b1, stop_mode);
    chk1("fast_clk", 1'b0, fast_clk_en);
    chk1("sig_en", 1'b0, signal_core_enable);
    chk3("clk_ctrl", v, clk_ctrl);
    // Low supply masked during stop
    supply_ok = 1'b0;
    cyc(3);
    chk1("sys_reset_b", 1'b1, sys_reset_b);
    supply_ok = 1'b1;
    cyc(1);
    // Every wake source, random enables
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      if (stop_mode !== 1'b1)
        stop_pulse();
      {twowire_start_int_enable, twowire_enable, supply_monitor_int_enable} = rnd[2:0];
      ex = wakes(i % 4, rnd[2], rnd[1], rnd[0]);
      u_dlrc_partner.raise(i % 4, 1 + int'(rnd[4:3]));
      cyc(2);
      chk1("stop_wake", ~ex, stop_mode);
      chk1("fast_clk", ex, fast_clk_en);
      chk3("clk_ctrl", v, clk_ctrl);
      chk1("sig_en", 1'b0, signal_core_enable);
    end
    // Reset during stop
    if (stop_mode !== 1'b1)
      stop_pulse();
    u_dlrc_partner.pin_low(5);
    watch(20, lows, last);
    chk1("stop", 1'b0, stop_mode);
    chk3("clk_ctrl", 3'h0, clk_ctrl);
    chk16("reset_vector", 16'h8000, reset_vector);
    // Brownout in run: full power-on sequence again
    supply_ok = 1'b0;
    cyc(3);
    chk1("sys_reset_b", 1'b0, sys_reset_b);
    supply_ok = 1'b1;
    watch(POR + 12, lows, last);
    chkn("bo_delay", POR, POR + 4, lows);
    chk1("por_flag", 1'b1, por_flag);
    chk1("sbd", 1'b0, stop_brownout_disable);
    // Idle: only enabled core interrupts wake, one vector each
    for (int s = 0; s < 2; s++) begin
      sig_en_wr = 1'b1;
      sig_en_wdata = 1'b1;
      sig_int_enable = 1'b0;
      cyc(1);
      sig_en_wr = 1'b0;
      idle_wr = 1'b1;
      cyc(1);
      idle_wr = 1'b0;
      cyc(1);
      chk1("idle", 1'b1, sig_idle);
      chk1("ip_freeze", 1'b1, ip_freeze);
      adc_buf_int = 1'b1;
      u_dlrc_partner.raise(0, 2);
      adc_buf_int = 1'b0;
      cyc(1);
      chk1("idle", 1'b1, sig_idle);
      sig_int_enable = 1'b1;
      cyc(1);
      {master_req_int, adc_buf_int} = (s == 0) ? 2'h2 : 2'h1;
      cyc(1);
      {master_req_int, adc_buf_int} = 2'h0;
      np = 0;
      for (int i = 0; i < 5; i++) begin
        if (sig_vector_take === 1'b1)
          np++;
        cyc(1);
      end
      chkn("vector", 1, 1, np);
      chk1("idle", 1'b0, sig_idle);
      chk1("ip_freeze", 1'b0, ip_freeze);
    end
    // Disabling the signal core ends idle
    idle_wr = 1'b1;
    cyc(1);
    idle_wr = 1'b0;
    sig_en_wr = 1'b1;
    sig_en_wdata = 1'b0;
    cyc(1);
    sig_en_wr = 1'b0;
    cyc(1);
    chk1("sig_reset_b", 1'b0, sig_core_reset_b);
    chk1("idle", 1'b0, sig_idle);
    print_verdict();
  end
endmodule
